// *** idma_pkg.sv ***
// Package of constants and types for the IDMA peripheral channel.
// Assumes a single 40 MHz clock domain; no register bus, all control is ports.
// Operation
// - Half width read splits words
// - Half width write packs halves
// - Watermark sets read burst length
// - Zero watermark: line of four/eight
// - Address word aligned
// - Address wraps at A24
// - Command bit picks PCI command
// - Read: request while data held
// - Count drops four per word
// - At most 2^22 words
// - Surplus prefetch discarded
// - Done when count ends
// - External done negates request
// - Second mode ignores external done
// - Write: request until buffer full
// - Write: burst at watermark
// - Code mismatch refused on single-address ack
// - Separate fast termination kinds
// - Active flag while busy
`default_nettype none
package idma_pkg;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_WIDTH = 32;
    localparam int WM_W = 6;
    localparam int CNT_W = 25;
    localparam int ADDR_W = 32;
    localparam logic [CNT_W-1:0] CNT_MAX = 25'h1000000;
    localparam logic [CNT_W-1:0] CNT_STEP = 25'h0000004;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h00000004;
    localparam logic [23:0] ADDR_LOW_MASK = 24'hfffffc;
    localparam logic [6:0] LINE_FOUR = 7'h04;
    localparam logic [6:0] LINE_EIGHT = 7'h08;
    localparam logic DIR_READ = 1'b0;
    localparam logic [3:0] PCI_MEM_READ_LINE = 4'he;
    localparam logic [3:0] PCI_MEM_READ_MULT = 4'hc;
    localparam logic [3:0] PCI_MEM_WRITE_INV = 4'hf;
    localparam logic [3:0] PCI_MEM_WRITE = 4'h7;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_BURST = 2'b11,
        ST_DRAIN = 2'b10
    } chan_state_t;
endpackage
`default_nettype wire

// *** idma_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes a single clock; flush empties it in one cycle.
`default_nettype none
module idma_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic flush_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    // Level
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign in_ready_out = (count != DEPTH[AW:0]);
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign level_out = count;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// *** idma_channel.sv ***
// IDMA peripheral channel: PCI master side burst engine and local bus handshake.
// Assumes PCI master handshake (word strobe) runs on clk_in; pin inputs are synchronised.
`default_nettype none
module idma_channel #(
    parameter int FIFO_WORDS = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Configuration
    input wire logic launch_in,
    input wire logic direction_in,
    input wire logic half_width_port_in,
    input wire logic second_mode_in,
    input wire logic cmd_select_in,
    input wire logic [idma_pkg::WM_W-1:0] fifo_watermark_in,
    input wire logic [1:0] line_size_sel_in,
    input wire logic [idma_pkg::ADDR_W-1:0] pci_target_address_in,
    input wire logic [idma_pkg::CNT_W-1:0] transfer_byte_count_in,
    input wire logic code_match_enable_in,
    input wire logic [3:0] code_field_in,
    input wire logic dual_addr_fast_term_in,
    input wire logic single_addr_fast_term_in,
    input wire logic done_clear_in,
    input wire logic channel_reset_request_in,
    // Local processor bus pins
    output logic service_request_n_out,
    input wire logic service_ack_n_in,
    input wire logic single_addr_ack_n_in,
    input wire logic [3:0] transfer_code_in,
    input wire logic ext_done_n_in,
    input wire logic [31:0] local_data_in,
    output logic [31:0] local_data_out,
    output logic local_data_oe_n_out,
    output logic fast_term_out,
    // PCI master side
    output logic pci_req_out,
    output logic [3:0] pci_cmd_out,
    output logic [idma_pkg::ADDR_W-1:0] pci_addr_out,
    output logic [6:0] pci_burst_len_out,
    input wire logic pci_word_in,
    input wire logic [31:0] pci_rdata_in,
    output logic [31:0] pci_wdata_out,
    input wire logic pci_burst_end_in,
    // Status
    output logic active_flag_out,
    output logic done_flag_out,
    output logic channel_reset_flag_out,
    output logic [idma_pkg::CNT_W-1:0] count_out,
    output logic [idma_pkg::ADDR_W-1:0] addr_out
);
    import idma_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] ack_sync;
    logic [1:0] sack_sync;
    logic [1:0] done_sync;
    logic [3:0] tc_s1;
    logic [3:0] tc_s2;
    logic [31:0] ld_s1;
    logic [31:0] ld_s2;
    logic ack_prev;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_sync <= 2'h3;
            sack_sync <= 2'h3;
            done_sync <= 2'h3;
            tc_s1 <= 4'h0;
            tc_s2 <= 4'h0;
            ld_s1 <= 32'h0;
            ld_s2 <= 32'h0;
            ack_prev <= 1'b1;
        end else begin
            ack_sync <= {ack_sync[0], service_ack_n_in};
            sack_sync <= {sack_sync[0], single_addr_ack_n_in};
            done_sync <= {done_sync[0], ext_done_n_in};
            tc_s1 <= transfer_code_in;
            tc_s2 <= tc_s1;
            ld_s1 <= local_data_in;
            ld_s2 <= ld_s1;
            ack_prev <= ack_sync[1] & sack_sync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle acceptance
    logic any_ack;
    logic code_ok;
    logic cycle_start;
    logic ext_done;
    assign any_ack = !ack_sync[1] || !sack_sync[1];
    assign code_ok = !code_match_enable_in || sack_sync[1] || (tc_s2 == code_field_in);
    assign cycle_start = any_ack && ack_prev && code_ok;
    assign ext_done = !second_mode_in && !done_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Channel state
    chan_state_t state;
    logic dir;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] fetch_left;
    logic [ADDR_W-1:0] addr;
    logic ext_stopped;
    logic done_flag;
    logic reset_flag;
    logic [6:0] burst_len;
    logic [6:0] burst_cnt;
    logic flush;

    // Fifo wiring
    logic f_in_valid;
    logic f_in_ready;
    logic [31:0] f_in_data;
    logic f_out_valid;
    logic f_out_ready;
    logic [31:0] f_out_data;
    logic [$clog2(FIFO_WORDS):0] f_level;

    always_comb begin
        if (fifo_watermark_in != '0) begin
            burst_len = 7'(fifo_watermark_in);
        end else if (line_size_sel_in[0]) begin
            burst_len = LINE_EIGHT;
        end else begin
            burst_len = LINE_FOUR;
        end
    end

    logic pci_xfer;
    logic deliver_ok;
    assign pci_xfer = (state == ST_BURST) && pci_word_in;
    assign flush = channel_reset_request_in && active_flag_out;
    // Surplus prefetch only enters the FIFO while words are still owed
    assign deliver_ok = fetch_left != '0;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
            dir <= DIR_READ;
            count <= '0;
            fetch_left <= '0;
            addr <= '0;
            burst_cnt <= '0;
        end else if (flush) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (launch_in) begin
                        dir <= direction_in;
                        count <= (transfer_byte_count_in > CNT_MAX) ? CNT_MAX
                                 : transfer_byte_count_in;
                        fetch_left <= (transfer_byte_count_in > CNT_MAX) ? CNT_MAX
                                      : transfer_byte_count_in;
                        addr <= {pci_target_address_in[31:2], 2'b00};
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    burst_cnt <= '0;
                    if (count == '0) begin
                        state <= ST_DRAIN;
                    end else if (dir == DIR_READ) begin
                        if (32'(f_level) + 32'(burst_len) <= FIFO_WORDS) begin
                            state <= ST_BURST;
                        end
                    end else if (32'(f_level) >= 32'(burst_len) ||
                                 32'(f_level) * 4 >= 32'(count)) begin
                        state <= ST_BURST;
                    end
                end
                ST_BURST: begin
                    if (pci_xfer) begin
                        count <= (count > CNT_STEP) ? count - CNT_STEP : '0;
                        addr <= {addr[31:24], addr[23:0] + ADDR_STEP[23:0]};
                        burst_cnt <= burst_cnt + 7'h1;
                    end
                    if (pci_burst_end_in || (pci_xfer && (burst_cnt + 7'h1 == burst_len
                        || count <= CNT_STEP))) begin
                        state <= ST_WAIT;
                    end
                end
                ST_DRAIN: begin
                    if (dir != DIR_READ || !f_out_valid) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            if (dir == DIR_READ && pci_xfer && deliver_ok) begin
                fetch_left <= (fetch_left > CNT_STEP) ? fetch_left - CNT_STEP : '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_flag <= 1'b0;
            reset_flag <= 1'b0;
            ext_stopped <= 1'b0;
        end else begin
            if (state == ST_DRAIN && (dir != DIR_READ || !f_out_valid)) begin
                done_flag <= 1'b1;
            end else if (done_clear_in) begin
                done_flag <= 1'b0;
            end
            if (flush) begin
                reset_flag <= 1'b1;
            end else if (done_clear_in) begin
                reset_flag <= 1'b0;
            end
            if (ext_done && state != ST_IDLE) begin
                ext_stopped <= 1'b1;
            end else if (state == ST_IDLE) begin
                ext_stopped <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Local bus data path with 16-bit split and pack
    logic half_sel;
    logic [15:0] half_hold;
    logic accept;
    assign accept = cycle_start && !ext_stopped && state != ST_IDLE;

    always_comb begin
        if (dir == DIR_READ) begin
            f_in_valid = pci_xfer && deliver_ok;
            f_in_data = pci_rdata_in;
            f_out_ready = accept && (!half_width_port_in || half_sel);
        end else begin
            f_in_valid = accept && (!half_width_port_in || half_sel);
            f_in_data = half_width_port_in ? {half_hold, ld_s2[31:16]} : ld_s2;
            f_out_ready = pci_xfer;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            half_sel <= 1'b0;
            half_hold <= 16'h0;
            local_data_out <= 32'h0;
            local_data_oe_n_out <= 1'b1;
            service_request_n_out <= 1'b1;
            fast_term_out <= 1'b0;
        end else begin
            if (flush || state == ST_IDLE) begin
                half_sel <= 1'b0;
            end else if (accept && half_width_port_in) begin
                half_sel <= !half_sel;
                if (dir != DIR_READ && !half_sel) begin
                    half_hold <= ld_s2[31:16];
                end
            end
            if (accept && dir == DIR_READ) begin
                local_data_out <= (half_width_port_in && !half_sel) ? {f_out_data[31:16], 16'h0}
                    : (half_width_port_in ? {f_out_data[15:0], 16'h0} : f_out_data);
                local_data_oe_n_out <= 1'b0;
            end else if (!any_ack) begin
                local_data_oe_n_out <= 1'b1;
            end
            if (dir == DIR_READ) begin
                service_request_n_out <= !(f_out_valid && !ext_stopped && !flush &&
                                           state != ST_IDLE);
            end else begin
                service_request_n_out <= !(f_in_ready && !ext_stopped && !flush &&
                                           state != ST_IDLE && state != ST_DRAIN);
            end
            fast_term_out <= !second_mode_in && (sack_sync[1] ? (!ack_sync[1] &&
                dual_addr_fast_term_in) : single_addr_fast_term_in);
        end
    end

    idma_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .flush_in(flush),
        .in_valid_in(f_in_valid),
        .in_ready_out(f_in_ready),
        .in_data_in(f_in_data),
        .out_valid_out(f_out_valid),
        .out_ready_in(f_out_ready),
        .out_data_out(f_out_data),
        .level_out(f_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // PCI side and status outputs
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pci_req_out <= 1'b0;
            pci_cmd_out <= 4'h0;
            pci_addr_out <= '0;
            pci_burst_len_out <= 7'h0;
            pci_wdata_out <= 32'h0;
            active_flag_out <= 1'b0;
            done_flag_out <= 1'b0;
            channel_reset_flag_out <= 1'b0;
            count_out <= '0;
            addr_out <= '0;
        end else begin
            pci_req_out <= (state == ST_BURST) && !flush;
            if (dir == DIR_READ) begin
                pci_cmd_out <= cmd_select_in ? PCI_MEM_READ_MULT : PCI_MEM_READ_LINE;
            end else begin
                pci_cmd_out <= cmd_select_in ? PCI_MEM_WRITE : PCI_MEM_WRITE_INV;
            end
            pci_addr_out <= {addr[31:24], addr[23:0] & ADDR_LOW_MASK};
            pci_burst_len_out <= burst_len;
            pci_wdata_out <= f_out_data;
            active_flag_out <= (state != ST_IDLE) && !flush;
            done_flag_out <= done_flag;
            channel_reset_flag_out <= reset_flag;
            count_out <= count;
            addr_out <= {addr[31:2], 2'b00};
        end
    end
endmodule
`default_nettype wire

// *** idma_channel_monitor.sv ***
// Checker for the IDMA peripheral channel, bound to its top module.
// Assumes one clock domain and the port names of idma_channel.
`default_nettype none
module idma_channel_monitor
    import idma_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Configuration
    input wire logic launch_in,
    input wire logic direction_in,
    input wire logic second_mode_in,
    input wire logic cmd_select_in,
    input wire logic [WM_W-1:0] fifo_watermark_in,
    input wire logic [1:0] line_size_sel_in,
    // Local bus
    input wire logic ext_done_n_in,
    input wire logic service_request_n_out,
    // PCI side
    input wire logic pci_req_out,
    input wire logic [3:0] pci_cmd_out,
    input wire logic [ADDR_W-1:0] pci_addr_out,
    input wire logic [6:0] pci_burst_len_out,
    input wire logic pci_word_in,
    // Status
    input wire logic active_flag_out,
    input wire logic done_flag_out,
    input wire logic channel_reset_flag_out,
    input wire logic [CNT_W-1:0] count_out,
    input wire logic [ADDR_W-1:0] addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] exp_len;
    logic [3:0] exp_cmd;
    assign exp_len = (fifo_watermark_in != '0) ? 7'(fifo_watermark_in) :
        (line_size_sel_in[0] ? LINE_EIGHT : LINE_FOUR);
    assign exp_cmd = direction_in ?
        (cmd_select_in ? PCI_MEM_WRITE : PCI_MEM_WRITE_INV) :
        (cmd_select_in ? PCI_MEM_READ_MULT : PCI_MEM_READ_LINE);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////
    a_burst_len: assert property (
        $rose(pci_req_out) |-> pci_burst_len_out == exp_len)
        else $error("bad burst length");
    a_cmd_pick: assert property (
        pci_req_out |-> pci_cmd_out == exp_cmd)
        else $error("wrong PCI command");
    a_addr_align: assert property (
        pci_req_out |-> pci_addr_out[1:0] == 2'b00 && addr_out[1:0] == 2'b00)
        else $error("address not word aligned");
    a_addr_wrap: assert property (
        pci_req_out && pci_word_in ##1 pci_req_out |=> addr_out[31:24] == $past(addr_out[31:24])
        && addr_out[23:0] == $past(addr_out[23:0]) + 24'h000004)
        else $error("bad address step");
    a_count_step: assert property (
        pci_req_out && pci_word_in ##1 pci_req_out |=>
        count_out == $past(count_out) - 25'h0000004)
        else $error("bad count step");
    a_done_count: assert property (
        $rose(done_flag_out) |-> count_out == '0)
        else $error("done with count left");
    a_active_go: assert property (
        launch_in && !active_flag_out |-> ##[1:3] active_flag_out)
        else $error("active flag missing after launch");
    a_req_quiet: assert property (
        !active_flag_out [*3] |-> service_request_n_out)
        else $error("request while idle");
    a_ext_stop: assert property (
        (!ext_done_n_in && !second_mode_in && active_flag_out) [*5]
        |-> service_request_n_out)
        else $error("request kept after external done");
    c_read_done: cover property (!direction_in && $rose(done_flag_out));
    c_write_done: cover property (direction_in && $rose(done_flag_out));
    c_reset: cover property ($rose(channel_reset_flag_out));
endmodule
bind idma_channel idma_channel_monitor mon_u (.*);
`default_nettype wire

// *** idma_pci_target.sv ***
// Behavioural PCI memory target facing the channel's master side.
// Assumes the channel holds its request for a whole burst.
`default_nettype none
module idma_pci_target (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Stall from the bench
    input wire logic hold_in,
    // Channel master side
    input wire logic req_in,
    input wire logic [6:0] len_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic word_out,
    output logic [31:0] rdata_out,
    output logic end_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] k;
    logic [23:0] base;
    logic take;
    logic [31:0] wq[$];
    // Burst address is latched while idle; off a data phase the bus shows the inverse
    assign rdata_out = word_out ? {8'hc3, base + {15'h0, k, 2'b00}} : ~{8'hc3, base};
    assign end_out = 1'b0;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            k <= 7'h00;
            word_out <= 1'b0;
            base <= 24'h0;
        end else if (!req_in) begin
            k <= 7'h00;
            word_out <= 1'b0;
            base <= addr_in[23:0];
        end else begin
            k <= k + 7'(word_out);
            word_out <= !hold_in && (k + 7'(word_out) < len_in);
        end
    end
    always @(posedge clk_in) begin
        // Write data register follows its data phase by one cycle
        if (take) wq.push_back(wdata_in);
        take <= req_in && word_out;
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for idma_channel with a PCI target model.
// Assumes the bench drives local bus pins 2 ns after each rising edge.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import idma_pkg::*;
    logic clk_in, nrst_in, launch_in, direction_in, half_width_port_in, hold;
    logic second_mode_in, cmd_select_in, code_match_enable_in, done_clear_in;
    logic channel_reset_request_in, service_ack_n_in, single_addr_ack_n_in;
    logic ext_done_n_in, dual_addr_fast_term_in, single_addr_fast_term_in, fast_term_out;
    logic service_request_n_out, local_data_oe_n_out, pci_req_out, pci_word_in;
    logic pci_burst_end_in, active_flag_out, done_flag_out, channel_reset_flag_out;
    logic [WM_W-1:0] fifo_watermark_in;
    logic [1:0] line_size_sel_in;
    logic [3:0] code_field_in, transfer_code_in, pci_cmd_out;
    logic [6:0] pci_burst_len_out;
    logic [31:0] local_data_in, local_data_out, pci_rdata_in, pci_wdata_out;
    logic [ADDR_W-1:0] pci_target_address_in, pci_addr_out, addr_out;
    logic [CNT_W-1:0] transfer_byte_count_in, count_out;
    int fails = 0;
    int n_tests = 0;
    idma_channel dut_u (.*);
    idma_pci_target far_u (.clk_in, .nrst_in, .hold_in(hold), .req_in(pci_req_out),
        .len_in(pci_burst_len_out), .addr_in(pci_addr_out), .wdata_in(pci_wdata_out),
        .word_out(pci_word_in), .rdata_out(pci_rdata_in), .end_out(pci_burst_end_in));
    ////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_in);
        #2;
    endtask
    task automatic check(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_on(ref logic s, input logic lvl);
        int i;
        i = 0;
        while (s !== lvl && i < 3000) begin
            tick();
            i++;
        end
        if (s !== lvl) begin
            check(s, lvl);
            tally_and_finish();
        end
    endtask
    function automatic logic [31:0] pat(int i);
        return {8'h6d, 8'(i), 16'hc0de ^ 16'(i)};
    endfunction
    task automatic launch(logic dir, hw, logic [WM_W-1:0] wm, logic [1:0] ls,
                          logic [31:0] a, logic [24:0] cnt, logic cmd);
        direction_in = dir;
        half_width_port_in = hw;
        fifo_watermark_in = wm;
        line_size_sel_in = ls;
        pci_target_address_in = a;
        transfer_byte_count_in = cnt;
        cmd_select_in = cmd;
        done_clear_in = 1'b1;
        launch_in = 1'b1;
        tick();
        done_clear_in = 1'b0;
        launch_in = 1'b0;
    endtask
    task automatic local_read(output logic [31:0] d, input logic sack);
        wait_on(service_request_n_out, 1'b0);
        if (sack) single_addr_ack_n_in = 1'b0;
        else service_ack_n_in = 1'b0;
        wait_on(local_data_oe_n_out, 1'b0);
        d = local_data_out;
        service_ack_n_in = 1'b1;
        single_addr_ack_n_in = 1'b1;
        wait_on(local_data_oe_n_out, 1'b1);
        tick(2);
    endtask
    task automatic local_write(logic [31:0] d);
        wait_on(service_request_n_out, 1'b0);
        local_data_in = d;
        service_ack_n_in = 1'b0;
        tick(4);
        service_ack_n_in = 1'b1;
        tick(3);
    endtask
    task automatic run_read(int n, logic [31:0] base, logic hw, logic sack);
        logic [31:0] d;
        logic [31:0] e;
        for (int i = 0; i < n; i++) begin
            e = {8'hc3, {base[23:2], 2'b00} + 24'(4 * i)};
            local_read(d, sack);
            if (hw) begin
                check(d[31:16], e[31:16]);
                local_read(d, sack);
                check(d[31:16], e[15:0]);
            end else begin
                check(d, e);
            end
        end
    endtask
    task automatic run_write(int n, logic hw, int stop);
        logic [31:0] w;
        far_u.wq.delete();
        for (int i = 0; i < n; i++) begin
            if (i == stop) begin
                tick(4);
                check(service_request_n_out, 1'b1);
                hold = 1'b0;
            end
            w = pat(i);
            if (hw) begin
                local_write({w[31:16], ~w[31:16]});
                local_write({w[15:0], ~w[15:0]});
            end else begin
                local_write(w);
            end
        end
        wait_on(done_flag_out, 1'b1);
        check(far_u.wq.size(), n);
        for (int i = 0; i < n; i++) check(far_u.wq[i], pat(i));
        check(count_out, '0);
    endtask
    task automatic tail_check();
        tick(20);
        check(service_request_n_out, 1'b1);
        check(done_flag_out, 1'b1);
        check(active_flag_out, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        {launch_in, direction_in, half_width_port_in, second_mode_in, hold} = '0;
        {cmd_select_in, code_match_enable_in, done_clear_in, nrst_in} = '0;
        {channel_reset_request_in, dual_addr_fast_term_in} = '0;
        single_addr_fast_term_in = 1'b1;
        {service_ack_n_in, single_addr_ack_n_in, ext_done_n_in} = 3'b111;
        {fifo_watermark_in, line_size_sel_in, code_field_in} = '0;
        {transfer_code_in, local_data_in, pci_target_address_in} = '0;
        transfer_byte_count_in = '0;
        repeat (16) @(posedge clk_in);
        #2;
        nrst_in = 1'b1;
        tick(2);
        // Read across the 16M boundary, external done ignored in second mode
        second_mode_in = 1'b1;
        ext_done_n_in = 1'b0;
        launch(1'b0, 1'b0, 6'h00, 2'b00, 32'h12fffff6, 25'h18, 1'b0);
        run_read(6, 32'h12fffff6, 1'b0, 1'b0);
        tail_check();
        // Half width read, code refused then accepted
        second_mode_in = 1'b0;
        ext_done_n_in = 1'b1;
        tick(3);
        code_match_enable_in = 1'b1;
        code_field_in = 4'ha;
        transfer_code_in = 4'h5;
        launch(1'b0, 1'b1, 6'h03, 2'b01, 32'h00000100, 25'h10, 1'b1);
        wait_on(service_request_n_out, 1'b0);
        single_addr_ack_n_in = 1'b0;
        tick(8);
        check(local_data_oe_n_out, 1'b1);
        check(fast_term_out, 1'b1);
        single_addr_ack_n_in = 1'b1;
        transfer_code_in = 4'ha;
        tick(3);
        run_read(4, 32'h00000100, 1'b1, 1'b1);
        tail_check();
        code_match_enable_in = 1'b0;
        // Write with the target stalled until the buffer refuses
        hold = 1'b1;
        launch(1'b1, 1'b0, 6'h04, 2'b00, 32'h00200000, 25'h50, 1'b0);
        run_write(20, 1'b0, 16);
        // Half width write, one line of eight
        launch(1'b1, 1'b1, 6'h00, 2'b01, 32'h00300000, 25'h20, 1'b1);
        run_write(8, 1'b1, -1);
        // External done in first mode, then channel reset
        launch(1'b0, 1'b0, 6'h00, 2'b01, 32'h00400000, 25'h20, 1'b0);
        run_read(2, 32'h00400000, 1'b0, 1'b0);
        ext_done_n_in = 1'b0;
        tick(6);
        check(service_request_n_out, 1'b1);
        tick(20);
        check(service_request_n_out, 1'b1);
        channel_reset_request_in = 1'b1;
        tick();
        channel_reset_request_in = 1'b0;
        tick(4);
        check(active_flag_out, 1'b0);
        check(channel_reset_flag_out, 1'b1);
        ext_done_n_in = 1'b1;
        // Oversized count is held to the largest transfer
        hold = 1'b1;
        launch(1'b0, 1'b0, 6'h00, 2'b00, 32'h00500000, 25'h1ffffff, 1'b0);
        tick();
        check(channel_reset_flag_out, 1'b0);
        check(count_out, 25'h1000000);
        channel_reset_request_in = 1'b1;
        tick();
        channel_reset_request_in = 1'b0;
        hold = 1'b0;
        tick(6);
        check(active_flag_out, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
